/* File: rtl/sewds_core.sv */
// Serial memory with watchdog and supply supervisor: link logic, status,
// array, write timer, watchdog and reset generator in one module.
// Assumes the host drives cs_n_i, sck_i, si_i; lowvdd_i comes from an analog
// trip detector; the open-drain reset pin is resolved outside.
// Behaviour
// - sample on sck rise, change output on fall
// - deselected output floats, standby unless busy
// - nothing accepted before first chip select fall
// - protect pin low with enable blocks status writes
// - started status write completes regardless of pin
// - enable bit zero ignores protect pin
// - low supply resets, held 200ms after recovery
// - watchdog fires on select idle too long
// - select falling edge restarts watchdog count
// - fixed reset polarity, open-drain active level
// - eight-bit instruction, everything MSB first
// - select low whole frame, first rise captures
// - stopped serial clock resumes where paused
// - writes need latch; latch clears after write
// - 06 sets latch; 04 clears latch, flag
// - 00 sets flag; status write also writes flag, cleared at power
// - 05 reads status; 01 writes status bits
// - 03 starts array read; 02 array write
// - status readable anytime; busy bit mirrors write
// - lock codes protect none, quarter, half, all
// - watchdog codes 1.4s, 600ms, 200ms, off
// - watchdog, lock, enable bits are nonvolatile
// - read streams with address increment and wrap
// - write commits only at byte boundary deselect
// - page write address wraps within page
module sewds_core #(
  parameter int ADDR_W = sewds_pkg::ADDR_W_DEF, // Array address width
  parameter int PAGE_BYTES = sewds_pkg::PAGE_BYTES_DEF, // Page size, power of two
  parameter int WDT_LONG_CYC = sewds_pkg::WDT_LONG_CYC, // Watchdog code 00
  parameter int WDT_MID_CYC = sewds_pkg::WDT_MID_CYC, // Watchdog code 01
  parameter int WDT_SHORT_CYC = sewds_pkg::WDT_SHORT_CYC, // Watchdog code 10
  parameter int RST_HOLD_CYC = sewds_pkg::RST_HOLD_CYC, // Reset extension
  parameter int WR_BUSY_CYC = sewds_pkg::WR_BUSY_CYC, // Write cycle length
  parameter bit RST_ACTIVE_HIGH = 1'b0 // Device variant reset polarity
) (
  input wire logic clock_i, // System clock, 40 MHz
  input wire logic arst_n_i, // Power-on reset, async, active low
  input wire logic factory_n_i, // Nonvolatile cell clear, async, active low
  input wire logic sck_i, // Serial clock from host
  input wire logic cs_n_i, // Chip select, active low
  input wire logic si_i, // Serial data in
  input wire logic wp_n_i, // Write protect pin, active low
  input wire logic lowvdd_i, // Low supply indication, async
  output logic so_o, // Serial data out
  output logic so_oe_n_o, // Serial out enable, low drives
  output logic rst_o, // Reset pin level when driven
  output logic rst_oe_n_o, // Reset pin enable, low drives active level
  output logic standby_o // Standby power mode
);

  localparam int PG_W = $clog2(PAGE_BYTES); // Page offset width
  localparam int DEPTH = 1 << ADDR_W; // Array bytes
  localparam int TW = 32; // Timer width

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (ADDR_W < 8 || ADDR_W > 16 || PG_W < 1 || PG_W > 8 || (1 << PG_W) != PAGE_BYTES ||
      PG_W > ADDR_W - 2 || RST_HOLD_CYC < 9 || WR_BUSY_CYC < 8 || WDT_SHORT_CYC < 4) begin : g_bad_param
    $error("sewds_core: unsupported parameter set");
  end

  // Array storage, shared by both domains
  logic [7:0] mem_r [DEPTH]; // Array cells
  // Nonvolatile and volatile status
  logic [1:0] wdt_sel_r; // Watchdog period code
  logic [1:0] lock_r; // Region lock code
  logic pen_r; // Protect pin enable
  logic flag_r; // User flag latch
  logic wel_r; // Write enable latch
  logic busy_r; // Internal write running
  logic [TW-1:0] busy_cnt_r; // Write cycle timer
  logic [TW-1:0] wdt_cnt_r; // Watchdog counter
  logic [TW-1:0] hold_cnt_r; // Reset extension counter
  // System-domain synchronisers
  logic cs_m1_r, cs_s_r, cs_d_r; // Chip select
  logic wp_m1_r, wp_s_r; // Protect pin
  logic vdd_m1_r, vdd_s_r; // Low supply
  logic tg_m1_r, tg_s_r; // Frame toggle
  logic ack_r; // Last frame handled
  logic rst_o_r, rst_oe_n_r, standby_r; // Output flops
  // Link domain
  logic armed_r; // First select fall seen
  logic link_rst; // Deselect or power reset
  logic [2:0] bitn_r; // Bit within byte
  sewds_pkg::sewds_phase_t ph_r; // Byte position
  logic [6:0] sh_r; // Input shifter
  logic [7:0] op_r; // Instruction register
  logic [15:0] addr_r; // Start address
  logic [7:0] sdat_r; // Status write data
  logic [PG_W-1:0] wptr_r; // Page buffer pointer
  logic [7:0] buf_r [PAGE_BYTES]; // Page buffer
  logic [PAGE_BYTES-1:0] mask_r; // Bytes loaded this frame
  logic end_ok_r; // Deselect here would commit
  logic tg_r; // Toggles on every frame
  logic [7:0] tx_r; // Output shifter
  logic rd_act_r; // Output phase active
  logic [ADDR_W-1:0] rdaddr_r; // Next read address
  logic bs1_r, bs_r, ws1_r, ws_r; // Busy and latch into link domain
  logic so_r, so_oe_n_r; // Pin flops

  logic [7:0] byte_in; // Completed byte
  logic byte_done; // Last bit of a byte
  logic [15:0] rd_full; // Read start address
  logic [7:0] stat_link; // Status as shifted out

  assign byte_in = {sh_r, si_i};
  assign byte_done = (bitn_r == 3'h7);
  assign rd_full = {addr_r[15:8], byte_in};
  assign link_rst = cs_n_i | ~arst_n_i;
  assign stat_link = {pen_r, flag_r, wdt_sel_r, lock_r, ws_r, bs_r};

  // ----------------------------------------------------------------
  // Power-up arming
  // ----------------------------------------------------------------
  // Clocked by the select fall itself so a frame already open at power-up is ignored
  always_ff @(negedge cs_n_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: framing
  // ----------------------------------------------------------------
  // Counters live only inside a frame; deselect clears them
  always_ff @(posedge sck_i or posedge link_rst) begin
    if (link_rst) begin
      bitn_r <= 3'h0;
      ph_r <= sewds_pkg::PH_OPC;
    end else if (armed_r) begin
      bitn_r <= bitn_r + 3'h1;
      if (byte_done && ph_r != sewds_pkg::PH_DATA) begin
        ph_r <= sewds_pkg::sewds_phase_t'(ph_r + 2'h1);
      end
    end
  end

  // Frame results survive deselect so the system side can act on them
  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sh_r <= 7'h00;
      op_r <= 8'h00;
      addr_r <= 16'h0000;
      sdat_r <= 8'h00;
      wptr_r <= '0;
      mask_r <= '0;
      end_ok_r <= 1'b0;
      tg_r <= 1'b0;
    end else if (!cs_n_i && armed_r) begin
      sh_r <= {sh_r[5:0], si_i};
      end_ok_r <= 1'b0;
      if (bitn_r == 3'h0 && ph_r == sewds_pkg::PH_OPC) begin
        tg_r <= ~tg_r; // New frame marker
        mask_r <= '0;
      end
      if (byte_done) begin
        case (ph_r)
          sewds_pkg::PH_OPC: begin
            op_r <= byte_in;
            end_ok_r <= (byte_in == sewds_pkg::OP_WLATCH_SET) || (byte_in == sewds_pkg::OP_WLATCH_CLR) ||
                        (byte_in == sewds_pkg::OP_FLAG_SET);
          end
          sewds_pkg::PH_AHI: begin
            addr_r[15:8] <= byte_in;
            sdat_r <= byte_in;
            end_ok_r <= (op_r == sewds_pkg::OP_STAT_WR);
          end
          sewds_pkg::PH_ALO: begin
            addr_r[7:0] <= byte_in;
            wptr_r <= byte_in[PG_W-1:0];
          end
          default: begin
            if (op_r == sewds_pkg::OP_ARR_WR) begin
              mask_r[wptr_r] <= 1'b1;
              wptr_r <= wptr_r + 1'b1;
              end_ok_r <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Page buffer data; plain storage, no reset needed
  always_ff @(posedge sck_i) begin
    if (!cs_n_i && armed_r && byte_done && ph_r == sewds_pkg::PH_DATA && op_r == sewds_pkg::OP_ARR_WR) begin
      buf_r[wptr_r] <= byte_in;
    end
  end

  // Busy and latch move on every serial clock rise; two flops keep them clean
  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bs1_r <= 1'b0;
      bs_r <= 1'b0;
      ws1_r <= 1'b0;
      ws_r <= 1'b0;
    end else begin
      bs1_r <= busy_r;
      bs_r <= bs1_r;
      ws1_r <= wel_r;
      ws_r <= ws1_r;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: output data
  // ----------------------------------------------------------------
  // Array cells only change while deselected, so a direct read is stable here
  always_ff @(posedge sck_i or posedge link_rst) begin
    if (link_rst) begin
      tx_r <= 8'h00;
      rd_act_r <= 1'b0;
      rdaddr_r <= '0;
    end else if (armed_r && byte_done && ((ph_r == sewds_pkg::PH_OPC && byte_in == sewds_pkg::OP_STAT_RD) ||
                 (ph_r != sewds_pkg::PH_OPC && op_r == sewds_pkg::OP_STAT_RD))) begin
      tx_r <= stat_link;
      rd_act_r <= 1'b1;
    end else if (armed_r && byte_done && ph_r == sewds_pkg::PH_ALO && op_r == sewds_pkg::OP_ARR_RD) begin
      tx_r <= mem_r[rd_full[ADDR_W-1:0]];
      rdaddr_r <= rd_full[ADDR_W-1:0] + 1'b1;
      rd_act_r <= 1'b1;
    end else if (armed_r && byte_done && ph_r == sewds_pkg::PH_DATA && op_r == sewds_pkg::OP_ARR_RD) begin
      tx_r <= mem_r[rdaddr_r];
      rdaddr_r <= rdaddr_r + 1'b1;
    end else if (armed_r) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // Pin changes only after falling edges; deselect floats it at once
  always_ff @(negedge sck_i or posedge link_rst) begin
    if (link_rst) begin
      so_r <= 1'b0;
      so_oe_n_r <= 1'b1;
    end else begin
      so_r <= tx_r[7];
      so_oe_n_r <= ~rd_act_r;
    end
  end

  assign so_o = so_r;
  assign so_oe_n_o = so_oe_n_r;

  // ----------------------------------------------------------------
  // System domain: input synchronisers
  // ----------------------------------------------------------------
  // Supply assumed low until seen otherwise
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_m1_r <= 1'b1;
      cs_s_r <= 1'b1;
      cs_d_r <= 1'b1;
      wp_m1_r <= 1'b1;
      wp_s_r <= 1'b1;
      vdd_m1_r <= 1'b1;
      vdd_s_r <= 1'b1;
      tg_m1_r <= 1'b0;
      tg_s_r <= 1'b0;
    end else begin
      cs_m1_r <= cs_n_i;
      cs_s_r <= cs_m1_r;
      cs_d_r <= cs_s_r;
      wp_m1_r <= wp_n_i;
      wp_s_r <= wp_m1_r;
      vdd_m1_r <= lowvdd_i;
      vdd_s_r <= vdd_m1_r;
      tg_m1_r <= tg_r;
      tg_s_r <= tg_m1_r;
    end
  end

  // ----------------------------------------------------------------
  // System domain: command commit
  // ----------------------------------------------------------------
  logic cs_fall, frame_end, commit, st_go, arr_go, lock_hit, busy_done;
  logic [1:0] top2;
  assign cs_fall = ~cs_s_r & cs_d_r;
  // Frame results are read only once select is high, when the link side is frozen
  assign frame_end = cs_s_r & ~cs_d_r & (tg_s_r != ack_r);
  assign commit = frame_end & end_ok_r & ~busy_r;
  assign st_go = commit & (op_r == sewds_pkg::OP_STAT_WR) & wel_r & ~(pen_r & ~wp_s_r);
  assign arr_go = commit & (op_r == sewds_pkg::OP_ARR_WR) & wel_r & ~lock_hit;
  assign top2 = addr_r[ADDR_W-1 -: 2];
  assign busy_done = busy_r & (busy_cnt_r == '0);

  // Locked regions stay readable; only writes look at this
  always_comb begin
    case (lock_r)
      sewds_pkg::LOCK_NONE: lock_hit = 1'b0;
      sewds_pkg::LOCK_QTR: lock_hit = (top2 == 2'h3);
      sewds_pkg::LOCK_HALF: lock_hit = top2[1];
      default: lock_hit = 1'b1;
    endcase
  end

  // Frame acknowledge
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_r <= 1'b0;
    end else if (frame_end) begin
      ack_r <= tg_s_r;
    end
  end

  // Bytes loaded this frame land at commit; the timer then models the cell programming
  always_ff @(posedge clock_i) begin
    if (arr_go) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (mask_r[i]) begin
          mem_r[{addr_r[ADDR_W-1:PG_W], PG_W'(i)}] <= buf_r[i];
        end
      end
    end
  end

  // Nonvolatile cells: only the cell clear resets them, never power-on reset; status writes load them
  always_ff @(posedge clock_i or negedge factory_n_i) begin
    if (!factory_n_i) begin
      pen_r <= sewds_pkg::PEN_RST;
      wdt_sel_r <= sewds_pkg::WDT_SEL_RST;
      lock_r <= sewds_pkg::LOCK_RST;
    end else if (st_go) begin
      pen_r <= sdat_r[sewds_pkg::SR_PEN];
      wdt_sel_r <= sdat_r[sewds_pkg::SR_WDT_LO +: 2];
      lock_r <= sdat_r[sewds_pkg::SR_LOCK_LO +: 2];
    end
  end

  // Volatile latches
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wel_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      if (busy_done) begin
        wel_r <= 1'b0;
      end
      if (commit && op_r == sewds_pkg::OP_WLATCH_SET) begin
        wel_r <= 1'b1;
      end
      if (commit && op_r == sewds_pkg::OP_WLATCH_CLR) begin
        wel_r <= 1'b0;
        flag_r <= 1'b0;
      end
      if (commit && op_r == sewds_pkg::OP_FLAG_SET) begin
        flag_r <= 1'b1;
      end
      if (st_go) begin
        flag_r <= sdat_r[sewds_pkg::SR_FLAG];
      end
    end
  end

  // Write timer; the pin is checked only at start, so a running cycle finishes
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_r <= 1'b0;
      busy_cnt_r <= '0;
    end else if (st_go || arr_go) begin
      busy_r <= 1'b1;
      busy_cnt_r <= TW'(WR_BUSY_CYC - 1);
    end else if (busy_done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      busy_cnt_r <= busy_cnt_r - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // System domain: watchdog and reset generator
  // ----------------------------------------------------------------
  logic [TW-1:0] wdt_lim;
  logic wdt_fire;
  always_comb begin
    case (wdt_sel_r)
      2'h0: wdt_lim = TW'(WDT_LONG_CYC);
      2'h1: wdt_lim = TW'(WDT_MID_CYC);
      2'h2: wdt_lim = TW'(WDT_SHORT_CYC);
      default: wdt_lim = '0;
    endcase
  end
  assign wdt_fire = (wdt_sel_r != sewds_pkg::WDT_OFF) && (wdt_cnt_r == wdt_lim - 1'b1);

  // Counts select idle time in either level; a fall or a bite restarts it, code off holds it at zero
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdt_cnt_r <= '0;
    end else if (cs_fall || wdt_fire || wdt_sel_r == sewds_pkg::WDT_OFF) begin
      wdt_cnt_r <= '0;
    end else begin
      wdt_cnt_r <= wdt_cnt_r + 1'b1;
    end
  end

  // Extension counter restarts while supply is low or on a watchdog bite
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_cnt_r <= TW'(RST_HOLD_CYC);
    end else if (vdd_s_r || wdt_fire) begin
      hold_cnt_r <= TW'(RST_HOLD_CYC);
    end else if (hold_cnt_r != '0) begin
      hold_cnt_r <= hold_cnt_r - 1'b1;
    end
  end

  // Open drain: the level is fixed, only the enable moves
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_o_r <= RST_ACTIVE_HIGH;
      rst_oe_n_r <= 1'b0;
      standby_r <= 1'b0;
    end else begin
      rst_o_r <= RST_ACTIVE_HIGH;
      rst_oe_n_r <= ~(vdd_s_r | (hold_cnt_r != '0));
      standby_r <= cs_s_r & ~busy_r;
    end
  end

  assign rst_o = rst_o_r;
  assign rst_oe_n_o = rst_oe_n_r;
  assign standby_o = standby_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb_sys @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_supply_back;
    $fell(vdd_s_r);
  endsequence
  sequence s_blocked_status;
    commit && op_r == sewds_pkg::OP_STAT_WR && pen_r && !wp_s_r;
  endsequence

  a_deselect_float: assert property (cs_s_r |-> so_oe_n_o)
    else $error("serial out driven while deselected");
  a_pin_blocks_status: assert property (s_blocked_status |=> !busy_r && $stable(lock_r))
    else $error("status write accepted with protect pin low");
  a_pin_ignored: assert property (commit && op_r == sewds_pkg::OP_STAT_WR && wel_r && !pen_r |=> busy_r)
    else $error("status write refused with pin function off");
  a_status_completes: assert property (st_go |=> busy_r [*4])
    else $error("status write cycle cut short");
  a_latch_gates_write: assert property ($rose(busy_r) |-> $past(wel_r))
    else $error("write started without latch");
  a_latch_clears: assert property ($fell(busy_r) |-> !wel_r)
    else $error("latch still set after write");
  a_lowvdd_reset: assert property (vdd_s_r |=> !rst_oe_n_o)
    else $error("reset not driven at low supply");
  a_reset_extends: assert property (s_supply_back |=> !rst_oe_n_o [*8])
    else $error("reset released too early");
  a_wdt_restart: assert property (cs_fall |=> wdt_cnt_r == '0)
    else $error("watchdog not restarted by select fall");
  a_wdt_bites: assert property (wdt_fire |-> ##2 !rst_oe_n_o)
    else $error("watchdog timeout gave no reset");
  a_flag_sets: assert property (commit && op_r == sewds_pkg::OP_FLAG_SET |=> flag_r)
    else $error("flag not set");
  a_whole_lock: assert property (commit && op_r == sewds_pkg::OP_ARR_WR && lock_r == 2'h3 |=> !busy_r)
    else $error("write into fully locked array");
  a_opcode_msb: assert property (@(posedge sck_i) disable iff (link_rst)
    armed_r && ph_r == sewds_pkg::PH_OPC && byte_done |=> op_r == $past(byte_in))
    else $error("instruction byte misassembled");

endmodule : sewds_core

/* File: rtl/sewds_pkg.sv */
// Shared constants for the serial memory / watchdog / supervisor block.
// Assumes a 40 MHz system clock; the serial link clock comes from the host.
package sewds_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 40000; // System clock in kHz
  localparam int WDT_LONG_MS = 1400; // Watchdog period, code 00
  localparam int WDT_MID_MS = 600; // Watchdog period, code 01
  localparam int WDT_SHORT_MS = 200; // Watchdog period, code 10
  localparam int RST_HOLD_MS = 200; // Reset extension after supply recovers
  localparam int WDT_LONG_CYC = WDT_LONG_MS * CLK_KHZ; // Cycles, code 00
  localparam int WDT_MID_CYC = WDT_MID_MS * CLK_KHZ; // Cycles, code 01
  localparam int WDT_SHORT_CYC = WDT_SHORT_MS * CLK_KHZ; // Cycles, code 10
  localparam int RST_HOLD_CYC = RST_HOLD_MS * CLK_KHZ; // Cycles of reset extension
  localparam int WR_BUSY_CYC = 4000; // Self-timed write cycle length in cycles

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W_DEF = 13; // Array address width
  localparam int PAGE_BYTES_DEF = 16; // Page buffer size

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WLATCH_SET = 8'h06; // write_latch_set_cmd
  localparam logic [7:0] OP_WLATCH_CLR = 8'h04; // write_latch_clear_cmd / user_flag_clear_cmd
  localparam logic [7:0] OP_FLAG_SET = 8'h00; // user_flag_set_cmd
  localparam logic [7:0] OP_STAT_RD = 8'h05; // status_read_cmd
  localparam logic [7:0] OP_STAT_WR = 8'h01; // status_write_cmd
  localparam logic [7:0] OP_ARR_RD = 8'h03; // Array read
  localparam logic [7:0] OP_ARR_WR = 8'h02; // Array write

  // ----------------------------------------------------------------
  // Status register layout and reset values
  // ----------------------------------------------------------------
  localparam int SR_BUSY = 0; // write_busy_bit
  localparam int SR_WLATCH = 1; // write_latch_bit
  localparam int SR_LOCK_LO = 2; // region_lock_lo, hi at +1
  localparam int SR_WDT_LO = 4; // wdt_period_sel_lo, hi at +1
  localparam int SR_FLAG = 6; // user_flag_bit
  localparam int SR_PEN = 7; // protect_pin_enable
  localparam logic [1:0] WDT_SEL_RST = 2'h0; // Blank-cell watchdog code
  localparam logic [1:0] LOCK_RST = 2'h0; // Blank-cell lock code
  localparam logic PEN_RST = 1'h0; // Blank-cell pin enable
  localparam logic [1:0] WDT_OFF = 2'h3; // Watchdog disabled code
  localparam logic [1:0] LOCK_NONE = 2'h0; // Nothing locked
  localparam logic [1:0] LOCK_QTR = 2'h1; // Top quarter locked
  localparam logic [1:0] LOCK_HALF = 2'h2; // Top half locked

  // Byte position within a frame
  typedef enum logic [1:0] {
    PH_OPC = 2'b00, // Instruction byte
    PH_AHI = 2'b01, // Address high or status data
    PH_ALO = 2'b10, // Address low
    PH_DATA = 2'b11 // Data stream
  } sewds_phase_t;

endpackage : sewds_pkg

/* File: dv/sewds_host.sv */
// SPI host model: mode 0 frames, MSB first, driven on request.
// Assumes the bench resolves the serial output wire for it.
module sewds_host (
  output logic sck_o, // Serial clock, idle low
  output logic cs_n_o, // Chip select, active low
  output logic si_o, // Data toward the device
  input wire logic so_i // Resolved serial output
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // One frame; clock stands still outside it
  task xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si_o = tx[i];
      #7.5 sck_o = 1'b1;
      rx = {rx[30:0], so_i};
      #7.5 sck_o = 1'b0;
    end
    #7.5 cs_n_o = 1'b1;
    // Released line shows inverse so stale data cannot pass
    si_o = ~si_o;
    #200;
  endtask : xfer
endmodule : sewds_host

/* File: dv/testbench.sv */
// Self-checking bench for the serial memory and supervisor core.
// Assumes short parameter values; host model drives the link.
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin \
  $display("mismatch %s exp %h got %h", nm, e, a); err_total++; end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i, arst_n_i, factory_n_i, wp_n_i, lowvdd_i, sck, cs_n, si;
  logic so_o, so_oe_n_o, rst_o, rst_oe_n_o, standby_o, so_w;
  logic [31:0] rx; // Last frame's received bits
  int err_total, cmp_count;
  // Undriven wire shows the inverse of the last value
  assign so_w = so_oe_n_o ? ~so_o : so_o;
  sewds_core #(.WDT_LONG_CYC(3000), .WDT_MID_CYC(2000), .WDT_SHORT_CYC(400),
    .RST_HOLD_CYC(50), .WR_BUSY_CYC(20)) sewds_core_inst (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .factory_n_i(factory_n_i), .sck_i(sck), .cs_n_i(cs_n),
    .si_i(si), .wp_n_i(wp_n_i), .lowvdd_i(lowvdd_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
    .rst_o(rst_o), .rst_oe_n_o(rst_oe_n_o), .standby_o(standby_o));
  sewds_host sewds_host_inst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so_w));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task end_sim;
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task fr(input int n, input logic [31:0] tx);
    sewds_host_inst.xfer(n, tx, rx);
  endtask : fr
  // Status read, low byte compared
  task st(input logic [7:0] e);
    fr(16, 32'h0500);
    `CHK("status", e, rx[7:0])
  endtask : st
  // Latch set then status write, wait out busy
  task wsr(input logic [7:0] d);
    fr(8, 32'h06);
    fr(16, {16'h0, 8'h01, d});
    #1000;
  endtask : wsr
  task pin(input logic w);
    @(negedge clock_i) wp_n_i = w;
    repeat (4) @(negedge clock_i);
  endtask : pin
  // Latch and flag commands, idle pins afterwards
  task t_latch;
    st(8'h00);
    fr(8, 32'h06);
    st(8'h02);
    fr(8, 32'h00);
    st(8'h42);
    fr(8, 32'h04);
    st(8'h00);
    `CHK("standby", 1'b1, standby_o)
    `CHK("so_oe_n", 1'b1, so_oe_n_o)
  endtask : t_latch
  // Byte write, busy seen from both sides, read back
  task t_array;
    fr(8, 32'h06);
    fr(32, 32'h020010a5);
    // Frame ends on a clock edge; step off it before looking
    @(negedge clock_i);
    `CHK("standby_busy", 1'b0, standby_o)
    fr(16, 32'h0500);
    `CHK("busy", 1'b1, rx[0])
    #1000;
    st(8'h00);
    fr(32, 32'h03001000);
    `CHK("array", 8'ha5, rx[7:0])
  endtask : t_array
  // Status writes against the protect pin and region lock
  task t_status;
    wsr(8'hb0);
    st(8'hb0);
    pin(1'b0);
    wsr(8'hbc);
    st(8'hb2);
    pin(1'b1);
    wsr(8'h30);
    pin(1'b0);
    wsr(8'h3c);
    st(8'h3c);
    fr(8, 32'h06);
    fr(32, 32'h0200105a);
    #1000;
    fr(32, 32'h03001000);
    `CHK("locked", 8'ha5, rx[7:0])
  endtask : t_status
  // Low supply asserts reset, then the extension runs out
  task t_supply;
    @(negedge clock_i);
    lowvdd_i = 1'b1;
    repeat (5) @(negedge clock_i);
    `CHK("rst_low", 1'b0, rst_oe_n_o)
    `CHK("rst_lvl", 1'b0, rst_o)
    lowvdd_i = 1'b0;
    repeat (40) @(negedge clock_i);
    `CHK("rst_hold", 1'b0, rst_oe_n_o)
    for (int i = 0; i < 30 && rst_oe_n_o !== 1'b1; i++) begin
      @(negedge clock_i);
    end
    `CHK("rst_free", 1'b1, rst_oe_n_o)
  endtask : t_supply
  // Short period: frames keep it quiet, silence makes it bite
  task t_watchdog;
    int n;
    wsr(8'h2c);
    repeat (2) begin
      repeat (300) @(negedge clock_i);
      st(8'h2c);
    end
    @(negedge clock_i);
    `CHK("wdt_fed", 1'b1, rst_oe_n_o)
    // Bounded wait; bite expected near 400 cycles after the last fall
    for (n = 0; n < 450 && rst_oe_n_o !== 1'b0; n++) begin
      @(negedge clock_i);
    end
    `CHK("wdt_bite", 1'b0, rst_oe_n_o)
    `CHK("wdt_late", 1'b1, n > 300)
  endtask : t_watchdog
  initial begin
    {arst_n_i, factory_n_i, lowvdd_i, wp_n_i} = 4'h1;
    err_total = 0;
    cmp_count = 0;
    repeat (3) @(negedge clock_i);
    {arst_n_i, factory_n_i} = 2'h3;
    t_latch();
    t_array();
    t_status();
    t_supply();
    t_watchdog();
    end_sim();
  end
endmodule : testbench
